//--- pmr_core_model.sv
// Processor core model: instruction completion and interrupt level
`timescale 1ns/1ps
`default_nettype none

module pmr_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench control
	input wire logic slow,
	input wire logic wake_req,
	// To the block
	output logic instr_done,
	output logic irq_wake
);
	logic [2:0] cnt;

	// Multi-byte instructions only: never two completions back to back
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= 3'h0;
			instr_done <= 1'h0;
			irq_wake <= 1'h0;
		end
		else
		begin
			cnt <= (cnt == (slow ? 3'h5 : 3'h1)) ? 3'h0 : cnt + 3'h1;
			instr_done <= (cnt == 3'h0);
			irq_wake <= wake_req;
		end
	end
endmodule : pmr_core_model
`default_nettype wire

//--- pmr_params.svh
// Offsets, field positions, reset values and timing counts of the power mode block
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define PMR_IDX_REGCTL 10'h0c9
`define PMR_IDX_PWRCTL 10'h087
`define PMR_IDX_OSCCTL 10'h100
`define PMR_IDX_OPTION 10'h101
`define PMR_IDX_STATUS 10'h102

// -----------------------------------------------------------------
// Regulator control fields
// -----------------------------------------------------------------
`define PMR_RC_MAIN_DIS 7
`define PMR_RC_BUS_PWR 6
`define PMR_RC_MAIN_LP 4
`define PMR_RC_STOP_SD 3
`define PMR_RC_CORE_LP 1
`define PMR_RC_WMASK 8'hbf
`define PMR_RC_RESET 8'h00

// -----------------------------------------------------------------
// Power control, oscillator control and option fields
// -----------------------------------------------------------------
`define PMR_PC_IDLE 0
`define PMR_PC_STOP 1
`define PMR_OC_SUSPEND 5
`define PMR_OPT_BUS_IE 0
`define PMR_OPT_MCD_EN 1

// -----------------------------------------------------------------
// Reset sequence and AXI4-Lite responses
// -----------------------------------------------------------------
`define PMR_START_ADDR 16'h0000
`define PMR_RESET_CYCLES 8
`define PMR_RESP_OKAY 2'h0
`define PMR_RESP_SLVERR 2'h2

`endif

//--- pmr_pkg.sv
// Types of the power mode and regulator control block
`default_nettype none
package pmr_pkg;

	typedef enum logic [2:0] {
		PMR_RUN = 3'h1,
		PMR_IDLE = 3'h2,
		PMR_STOP = 3'h4
	} pmr_mode_e;

	typedef struct packed {
		pmr_mode_e mode;
		logic idle_arm;
		logic stop_arm;
		logic susp_arm;
		logic suspended;
		logic [7:0] regctl;
		logic [5:0] gen_flags;
		logic [1:0] option;
		logic aw_have;
		logic [11:0] awaddr;
		logic w_have;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic bus_pwr_d;
		logic bus_pwr_irq;
		logic cpu_halt;
		logic osc_stop;
		logic periph_stop;
		logic core_sd;
		logic resume;
		logic wake_irq;
		logic reset_start;
		logic [15:0] fetch_addr;
	} pmr_state_s;

endpackage : pmr_pkg

`default_nettype wire

//--- pmr_pulse.sv
// Stretches a start pulse into a reset level of fixed length
`timescale 1ns/1ps
`default_nettype none

module pmr_pulse #(
	parameter int CYCLES = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Pulse
	input wire logic start,
	output logic active
);

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic active;
	} pmr_pulse_s;

	pmr_pulse_s s;
	pmr_pulse_s next_s;

	always_comb
	begin
		next_s = s;
		if (start)
		begin
			next_s.cnt = CW'(CYCLES - 1);
			next_s.active = 1'b1;
		end
		else if (s.cnt != '0)
			next_s.cnt = s.cnt - CW'(1);
		else
			next_s.active = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign active = s.active;

endmodule : pmr_pulse

`default_nettype wire

//--- pmr_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pmr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmr_sync_s;

	pmr_sync_s s;
	pmr_sync_s next_s;

	always_comb
	begin
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s.s1 <= INIT;
			s.s2 <= INIT;
		end
		else if (ce)
			s <= next_s;
	end

	assign q = s.s2;

endmodule : pmr_sync

`default_nettype wire

//--- pmr_top.sv
// Power mode sequencer and regulator control with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_params.svh"

// Operation
// - Bit 7 set switches main regulator off
// - Bit 6 reads synchronised bus power level
// - Bit 4 puts main regulator in low power
// - Bit 3 shuts core regulator in stop
// - Bit 1 puts core regulator in low power
// - Regulator control decoded at index 0xc9
// - Idle bit halts core after instruction
// - Enabled interrupt ends idle and resumes
// - Reset ends idle, restarts at zero
// - Watchdog reset ends idle mode
// - Stop bit stops oscillator, core, peripherals
// - Stop ends only by reset sequence
// - Enabled missing clock detector ends stop unless bit 3 set
// - Suspend bit stops internal oscillator only
// - Resume signalling or reset ends suspend
// - Suspend wake continues, raises wake interrupt
// - Bus power edges raise enabled interrupt
module pmr_top
	import pmr_pkg::*;
#(
	parameter int RESET_CYCLES = `PMR_RESET_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic instr_done,
	input wire logic irq_wake,
	input wire logic watchdog_reset,
	input wire logic mcd_reset,
	input wire logic other_reset,
	// Pins
	input wire logic rst_pin_n,
	input wire logic bus_power_pin,
	input wire logic usb_resume_pin,
	// Power and clock controls
	output logic cpu_halt,
	output logic int_osc_stop,
	output logic periph_clk_stop,
	output logic main_regulator_off,
	output logic main_regulator_low_power,
	output logic core_regulator_low_power,
	output logic core_regulator_shutdown,
	// Reset and wake
	output logic sys_reset,
	output logic [15:0] fetch_addr,
	output logic resume_pulse,
	output logic wake_irq,
	output logic bus_power_irq
);

	import pmr_pkg::*;

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [2:0] pins_s;
	logic rst_pin_s;
	logic bus_pwr_s;
	logic usb_resume_s;

	pmr_sync #(
		.W(3),
		.INIT(3'h4)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({rst_pin_n, bus_power_pin, usb_resume_pin}),
		.q(pins_s)
	);

	assign rst_pin_s = ~pins_s[2];
	assign bus_pwr_s = pins_s[1];
	assign usb_resume_s = pins_s[0];

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	function automatic logic [9:0] word_index(input logic [11:0] addr);
		word_index = addr[11:2];
	endfunction : word_index

	function automatic logic index_hit(input logic [9:0] idx);
		index_hit = (idx == `PMR_IDX_REGCTL) || (idx == `PMR_IDX_PWRCTL) ||
			(idx == `PMR_IDX_OSCCTL) || (idx == `PMR_IDX_OPTION) ||
			(idx == `PMR_IDX_STATUS);
	endfunction : index_hit

	pmr_state_s s;
	pmr_state_s next_s;
	logic reset_hit;
	logic do_write;
	logic [9:0] widx;
	logic [9:0] ridx;
	logic [7:0] rbyte;

	// -----------------------------------------------------------------
	// Reset sources by mode
	// -----------------------------------------------------------------
	always_comb
	begin
		if (s.mode == PMR_STOP)
		begin
			// Core regulator shut down leaves only the pin
			if (s.regctl[`PMR_RC_STOP_SD])
				reset_hit = rst_pin_s;
			else
				reset_hit = rst_pin_s || other_reset ||
					(mcd_reset && s.option[`PMR_OPT_MCD_EN]);
		end
		else
			reset_hit = rst_pin_s || other_reset || watchdog_reset ||
				(mcd_reset && s.option[`PMR_OPT_MCD_EN]);
	end

	// -----------------------------------------------------------------
	// Register read mux
	// -----------------------------------------------------------------
	always_comb
	begin
		ridx = word_index(s_axi_araddr);
		rbyte = 8'h00;
		case (ridx)
			`PMR_IDX_REGCTL:
			begin
				rbyte = s.regctl;
				rbyte[`PMR_RC_BUS_PWR] = bus_pwr_s;
			end
			`PMR_IDX_PWRCTL:
				rbyte = {s.gen_flags, 2'h0};
			`PMR_IDX_OSCCTL:
				rbyte[`PMR_OC_SUSPEND] = s.suspended;
			`PMR_IDX_OPTION:
				rbyte = {6'h00, s.option};
			`PMR_IDX_STATUS:
				rbyte = {4'h0, bus_pwr_s, s.suspended,
					s.mode == PMR_STOP, s.mode == PMR_IDLE};
			default:
				rbyte = 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.resume = 1'b0;
		next_s.wake_irq = 1'b0;
		next_s.bus_pwr_irq = 1'b0;
		next_s.reset_start = 1'b0;
		widx = word_index(s.awaddr);
		do_write = s.aw_have && s.w_have && !s.bvalid;

		// Bus power edges, either direction
		next_s.bus_pwr_d = bus_pwr_s;
		if ((bus_pwr_s != s.bus_pwr_d) && s.option[`PMR_OPT_BUS_IE])
			next_s.bus_pwr_irq = 1'b1;

		// Write address and data, taken in either order
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wstrb0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;

		// Mode sequencer
		case (s.mode)
			PMR_RUN:
			begin
				if (instr_done)
				begin
					if (s.stop_arm)
						next_s.mode = PMR_STOP;
					else if (s.idle_arm)
						next_s.mode = PMR_IDLE;
					if (s.susp_arm)
						next_s.suspended = 1'b1;
					next_s.stop_arm = 1'b0;
					next_s.idle_arm = 1'b0;
					next_s.susp_arm = 1'b0;
				end
			end
			PMR_IDLE:
			begin
				if (irq_wake)
				begin
					next_s.mode = PMR_RUN;
					next_s.resume = 1'b1;
				end
			end
			PMR_STOP:
				next_s.mode = PMR_STOP;
			default:
				next_s.mode = PMR_RUN;
		endcase

		if (s.suspended && usb_resume_s)
		begin
			next_s.suspended = 1'b0;
			next_s.wake_irq = 1'b1;
		end

		// Register write
		if (do_write)
		begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = index_hit(widx) ? `PMR_RESP_OKAY : `PMR_RESP_SLVERR;
			if (s.wstrb0)
			begin
				case (widx)
					`PMR_IDX_REGCTL:
						next_s.regctl = s.wdata & `PMR_RC_WMASK;
					`PMR_IDX_PWRCTL:
					begin
						next_s.gen_flags = s.wdata[7:2];
						if (s.wdata[`PMR_PC_IDLE])
							next_s.idle_arm = 1'b1;
						if (s.wdata[`PMR_PC_STOP])
							next_s.stop_arm = 1'b1;
					end
					`PMR_IDX_OSCCTL:
						if (s.wdata[`PMR_OC_SUSPEND])
							next_s.susp_arm = 1'b1;
					`PMR_IDX_OPTION:
						next_s.option = s.wdata[1:0];
					default:
						next_s.option = next_s.option;
				endcase
			end
		end

		// Register read
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata = {24'h000000, rbyte};
			next_s.rresp = index_hit(ridx) ? `PMR_RESP_OKAY : `PMR_RESP_SLVERR;
		end

		// Reset event returns mode, arms and registers to the start state
		if (reset_hit)
		begin
			next_s.mode = PMR_RUN;
			next_s.idle_arm = 1'b0;
			next_s.stop_arm = 1'b0;
			next_s.susp_arm = 1'b0;
			next_s.suspended = 1'b0;
			next_s.regctl = `PMR_RC_RESET;
			next_s.gen_flags = 6'h00;
			next_s.option = 2'h0;
			next_s.resume = 1'b0;
			next_s.wake_irq = 1'b0;
			next_s.reset_start = 1'b1;
			next_s.fetch_addr = `PMR_START_ADDR;
		end

		next_s.awready = !next_s.aw_have && !next_s.bvalid;
		next_s.wready = !next_s.w_have && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;

		next_s.cpu_halt = next_s.mode != PMR_RUN;
		next_s.osc_stop = (next_s.mode == PMR_STOP) || next_s.suspended;
		next_s.periph_stop = next_s.mode == PMR_STOP;
		next_s.core_sd = (next_s.mode == PMR_STOP) &&
			next_s.regctl[`PMR_RC_STOP_SD];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.mode <= PMR_RUN;
			s.regctl <= `PMR_RC_RESET;
			s.fetch_addr <= `PMR_START_ADDR;
		end
		else if (ce)
			s <= next_s;
	end

	// -----------------------------------------------------------------
	// Reset sequence length
	// -----------------------------------------------------------------
	pmr_pulse #(
		.CYCLES(RESET_CYCLES)
	) u_pulse (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(s.reset_start),
		.active(sys_reset)
	);

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign cpu_halt = s.cpu_halt;
	assign int_osc_stop = s.osc_stop;
	assign periph_clk_stop = s.periph_stop;
	assign main_regulator_off = s.regctl[`PMR_RC_MAIN_DIS];
	assign main_regulator_low_power = s.regctl[`PMR_RC_MAIN_LP];
	assign core_regulator_low_power = s.regctl[`PMR_RC_CORE_LP];
	assign core_regulator_shutdown = s.core_sd;
	assign fetch_addr = s.fetch_addr;
	assign resume_pulse = s.resume;
	assign wake_irq = s.wake_irq;
	assign bus_power_irq = s.bus_pwr_irq;

endmodule : pmr_top

`default_nettype wire

//--- pmr_top_sva.sv
// Concurrent checks on the ports of the power mode block
`timescale 1ns/1ps
`default_nettype none

module pmr_top_sva #(
	parameter int RESET_CYCLES = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs and the write response valid output
	input wire logic instr_done,
	input wire logic irq_wake,
	input wire logic watchdog_reset,
	input wire logic rst_pin_n,
	input wire logic bus_power_pin,
	input wire logic s_axi_bvalid,
	// Outputs
	input wire logic cpu_halt,
	input wire logic int_osc_stop,
	input wire logic periph_clk_stop,
	input wire logic main_regulator_off,
	input wire logic main_regulator_low_power,
	input wire logic core_regulator_low_power,
	input wire logic core_regulator_shutdown,
	input wire logic sys_reset,
	input wire logic [15:0] fetch_addr,
	input wire logic resume_pulse,
	input wire logic wake_irq,
	input wire logic bus_power_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic [7:0] len;

	// Length of the current reset pulse
	always_ff @(posedge clk)
	begin
		if (rst || !sys_reset)
			len <= 8'h0;
		else
			len <= len + 8'h1;
	end

	a_halt_after_instr: assert property (
		$rose(cpu_halt) |-> $past(instr_done))
		else $error("core halted without instruction end");
	a_idle_wake: assert property (
		cpu_halt && !periph_clk_stop && irq_wake && !watchdog_reset && !sys_reset
		|=> !cpu_halt && resume_pulse)
		else $error("idle not left on interrupt");
	a_reset_len: assert property (
		$fell(sys_reset) |-> len == RESET_CYCLES && fetch_addr == 16'h0)
		else $error("reset pulse length or start address wrong");
	a_wdog_idle: assert property (
		cpu_halt && !periph_clk_stop && watchdog_reset |-> ##[1:2] sys_reset)
		else $error("watchdog did not end idle");
	a_stop_outputs: assert property (
		$rose(periph_clk_stop) |-> cpu_halt && int_osc_stop && $past(instr_done))
		else $error("stop entry outputs wrong");
	a_stop_exit: assert property (
		$fell(periph_clk_stop) |-> ##[0:1] sys_reset)
		else $error("stop left without reset");
	a_wdog_stop: assert property (
		periph_clk_stop && watchdog_reset && rst_pin_n && !sys_reset |=> periph_clk_stop)
		else $error("watchdog ended stop");
	a_sd_hold: assert property (
		core_regulator_shutdown && rst_pin_n && $past(rst_pin_n) && $past(rst_pin_n, 2)
		&& $past(rst_pin_n, 3) && $past(rst_pin_n, 4) |=> core_regulator_shutdown)
		else $error("shutdown stop left without pin");
	a_susp_wake: assert property (
		$rose(wake_irq) |-> !int_osc_stop && $past(int_osc_stop) && !cpu_halt)
		else $error("wake interrupt without suspend exit");
	a_bus_edge: assert property (
		bus_power_irq |-> $past(bus_power_pin, 2) != $past(bus_power_pin, 6))
		else $error("bus power interrupt without edge");
	a_regs_write: assert property (
		$changed({main_regulator_off, main_regulator_low_power, core_regulator_low_power})
		|-> ##[0:1] (s_axi_bvalid || sys_reset))
		else $error("regulator output changed without write");
endmodule : pmr_top_sva

bind pmr_top pmr_top_sva #(.RESET_CYCLES(RESET_CYCLES)) i_sva (.clk, .rst, .instr_done,
	.irq_wake, .watchdog_reset, .rst_pin_n, .bus_power_pin, .s_axi_bvalid, .cpu_halt,
	.int_osc_stop, .periph_clk_stop, .main_regulator_off, .main_regulator_low_power,
	.core_regulator_low_power, .core_regulator_shutdown, .sys_reset, .fetch_addr,
	.resume_pulse, .wake_irq, .bus_power_irq);
`default_nettype wire

//--- power_mode_and_regulator_control_tb.sv
// Self-checking bench of the power mode block
`timescale 1ns/1ps
`default_nettype none
`include "pmr_params.svh"

module power_mode_and_regulator_control_tb;
	logic clk = 1'h0, rst = 1'h1, ce = 1'h1, slow = 1'h0, wake_req = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h1, rq = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_done, irq_wake;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic bus_power_pin = 1'h0, usb_resume_pin = 1'h0, cpu_halt, int_osc_stop;
	logic periph_clk_stop, main_regulator_off, main_regulator_low_power;
	logic core_regulator_low_power, core_regulator_shutdown, sys_reset;
	logic resume_pulse, wake_irq, bus_power_irq;
	logic [15:0] fetch_addr;
	int errors = 0, n_compared = 0;
	int ign[3] = '{2, 0, 1};

	pmr_top #(.RESET_CYCLES(2)) i_dut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.instr_done, .irq_wake, .watchdog_reset(rq[0]), .mcd_reset(rq[2]),
		.other_reset(rq[1]), .rst_pin_n(!rq[3]), .bus_power_pin, .usb_resume_pin, .cpu_halt,
		.int_osc_stop, .periph_clk_stop, .main_regulator_off, .main_regulator_low_power,
		.core_regulator_low_power, .core_regulator_shutdown, .sys_reset, .fetch_addr,
		.resume_pulse, .wake_irq, .bus_power_irq);
	pmr_core_model i_core (.clk, .rst, .slow, .wake_req, .instr_done, .irq_wake);

	always #2.5 clk = ~clk;

	task automatic end_sim;
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task automatic fail(input string nm);
		errors++;
		$display("Error %s expected response seen timeout", nm);
		end_sim();
	endtask : fail

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Regulator control read-back: bit 6 live bus power, the rest as written
	function automatic logic [31:0] exp_regctl(input logic [7:0] w, input logic vbus);
		exp_regctl = {24'h0, w[7], vbus, w[5:0]};
	endfunction : exp_regctl

	task automatic wait_v(ref logic s, input logic v, input string nm);
		for (int n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (s === v)
				return;
		end
		fail(nm);
	endtask : wait_v

	task automatic pulse(input int i);
		rq[i] <= 1'h1;
		@(posedge clk);
		rq <= 4'h0;
	endtask : pulse

	task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d);
		logic a, w;
		a = 1'h1;
		w = 1'h1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (int n = 0; n < 100 && (a || w); n++)
		begin
			@(posedge clk);
			if (a && s_axi_awready === 1'h1)
			begin
				a = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready === 1'h1)
			begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		if (a || w)
			fail("write take");
		s_axi_bready <= 1'h1;
		wait_v(s_axi_bvalid, 1'h1, "bvalid");
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input logic [9:0] idx);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		wait_v(s_axi_arready, 1'h1, "arready");
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		wait_v(s_axi_rvalid, 1'h1, "rvalid");
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd

	initial
	begin
		logic [7:0] d;
		int k, c;
		void'($urandom(5));
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		axi_rd(`PMR_IDX_REGCTL);
		chk("regctl reset", exp_regctl(8'h00, bus_power_pin), rd);
		for (k = 0; k < 8; k++)
		begin
			d = (k == 0) ? 8'h40 : 8'($urandom);
			if (d[7])
				d[1] = 1'h0;
			bus_power_pin <= (k != 0) & d[0];
			axi_wr(`PMR_IDX_REGCTL, d);
			repeat (4) @(posedge clk);
			axi_rd(`PMR_IDX_REGCTL);
			chk("regctl", exp_regctl(d, bus_power_pin), rd);
			chk("reg outputs", {d[7], d[4], d[1]},
				{main_regulator_off, main_regulator_low_power, core_regulator_low_power});
		end
		s_axi_wstrb <= 4'h0;
		axi_wr(`PMR_IDX_REGCTL, ~d);
		s_axi_wstrb <= 4'h1;
		chk("masked bresp", 2'h0, rs);
		axi_rd(`PMR_IDX_REGCTL);
		chk("masked write", exp_regctl(d, bus_power_pin), rd);
		axi_wr(10'h200, 8'h55);
		chk("unmapped bresp", 2'h2, rs);
		axi_rd(10'h200);
		chk("unmapped rresp", 2'h2, rs);
		axi_wr(`PMR_IDX_OPTION, 8'h01);
		for (k = 0; k < 3; k++)
		begin
			if (k == 2)
				axi_wr(`PMR_IDX_OPTION, 8'h00);
			bus_power_pin <= ~bus_power_pin;
			c = 0;
			repeat (8)
			begin
				@(posedge clk);
				c += (bus_power_irq === 1'h1);
			end
			chk("bus power irq count", (k < 2), c);
		end
		slow <= 1'h1;
		axi_wr(`PMR_IDX_PWRCTL, 8'hfd);
		wait_v(cpu_halt, 1'h1, "idle entry");
		chk("idle periph", 1'h0, periph_clk_stop);
		axi_rd(`PMR_IDX_PWRCTL);
		chk("power control", 32'hfc, rd);
		axi_rd(`PMR_IDX_STATUS);
		chk("status idle", {28'h0, bus_power_pin, 3'h1}, rd);
		wake_req <= 1'h1;
		wait_v(resume_pulse, 1'h1, "resume");
		wake_req <= 1'h0;
		chk("idle left", 1'h0, cpu_halt);
		axi_wr(`PMR_IDX_REGCTL, 8'h12);
		axi_wr(`PMR_IDX_PWRCTL, 8'h01);
		wait_v(cpu_halt, 1'h1, "idle entry");
		pulse(0);
		wait_v(sys_reset, 1'h1, "watchdog reset");
		chk("fetch address", 16'h0, fetch_addr);
		wait_v(sys_reset, 1'h0, "reset end");
		chk("halt after reset", 1'h0, cpu_halt);
		axi_rd(`PMR_IDX_REGCTL);
		chk("regctl after reset", exp_regctl(8'h00, bus_power_pin), rd);
		for (k = 0; k < 3; k++)
		begin
			axi_wr(`PMR_IDX_OPTION, {6'h0, k != 0, 1'h0});
			axi_wr(`PMR_IDX_REGCTL, {4'h0, k == 2, 3'h0});
			axi_wr(`PMR_IDX_PWRCTL, 8'h02);
			wait_v(periph_clk_stop, 1'h1, "stop entry");
			chk("stop outputs", {2'h3, k == 2},
				{cpu_halt, int_osc_stop, core_regulator_shutdown});
			axi_rd(`PMR_IDX_STATUS);
			chk("status stop", {28'h0, bus_power_pin, 3'h2}, rd);
			pulse(ign[k]);
			repeat (8) @(posedge clk);
			chk("stop held", 1'h1, periph_clk_stop);
			pulse(k + 1);
			wait_v(sys_reset, 1'h1, "stop reset");
			wait_v(sys_reset, 1'h0, "reset end");
			chk("stop left", 1'h0, periph_clk_stop);
		end
		axi_wr(`PMR_IDX_REGCTL, 8'h12);
		for (k = 0; k < 12; k++)
			wait_v(instr_done, 1'h1, "instruction");
		axi_wr(`PMR_IDX_OSCCTL, 8'h20);
		wait_v(int_osc_stop, 1'h1, "suspend entry");
		chk("suspend core", 2'h0, {cpu_halt, periph_clk_stop});
		axi_rd(`PMR_IDX_OSCCTL);
		chk("suspend state", 32'h20, rd);
		usb_resume_pin <= 1'h1;
		wait_v(wake_irq, 1'h1, "wake irq");
		chk("suspend left", 1'h0, int_osc_stop);
		usb_resume_pin <= 1'h0;
		axi_rd(`PMR_IDX_REGCTL);
		chk("regctl kept", exp_regctl(8'h12, bus_power_pin), rd);
		end_sim();
	end
endmodule : power_mode_and_regulator_control_tb
`default_nettype wire
